/* ebi_defines.svh */
`ifndef EBI_DEFINES_SVH
`define EBI_DEFINES_SVH
// Bus widths
`define EBI_DATA_W       32
`define EBI_HALF_W       16
`define EBI_ADDR_W       26
`define EBI_ADDR_MIN_W   20
`define EBI_ADDR_MID_W   24
`define EBI_LANES        4
`define EBI_NUM_CS       4
// Bus clock is system clock divided by this
`define EBI_CLK_DIV      2
// Wait state counter width and default
`define EBI_WS_W         4
`define EBI_WS_DEFAULT   4'h0
// Burst beat counter width
`define EBI_BEAT_W       2
// Access sizes
`define EBI_SZ_BYTE      2'h0
`define EBI_SZ_HALF      2'h1
`define EBI_SZ_WORD      2'h2
`endif

/* ebi_pkg.sv */
package ebi_pkg;
	// Core side request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0]  size;
		logic        write;
		logic        burst;
	} ebi_req_t;
	// Pin side bundle
	typedef struct packed {
		logic [25:0] addr;
		logic [31:0] dout;
		logic [3:0]  cs_n;
		logic [3:0]  strobe_n;
		logic        oe_n;
		logic        data_oe_n;
		logic        adv_n;
	} pin_out_t;
	// Controller states, Gray along the main path
	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_addr  = 3'b001,
		st_wait  = 3'b011,
		st_data  = 3'b010,
		st_done  = 3'b110
	} ebi_state_t;
endpackage

/* lane_strobe_gen.sv */
`timescale 1ns/1ps
`include "ebi_defines.svh"
// Byte lane strobe pattern from size and address
module lane_strobe_gen #(
	parameter bit HALF_BUS = 1'b0
) (
	// Access
	input  wire logic [1:0] size,
	input  wire logic [1:0] addr_lo,
	// Pattern, bit 0 is lane DATA[0:7]
	output logic      [3:0] lanes
);
	// Lane 0 is the most significant byte, so byte 0 maps to lane 0
	always_comb begin
		lanes = 4'h0;
		case (size)
			`EBI_SZ_BYTE: begin
				if (HALF_BUS)
					lanes[{1'b0, addr_lo[0]}] = 1'b1;
				else
					lanes[addr_lo] = 1'b1;
			end
			`EBI_SZ_HALF: begin
				if (HALF_BUS)
					lanes = 4'h3;
				else
					lanes = addr_lo[1] ? 4'hc : 4'h3;
			end
			default: begin
				lanes = HALF_BUS ? 4'h3 : 4'hf;
			end
		endcase
	end
endmodule

/* external_sram_bus.sv */
`timescale 1ns/1ps
`include "ebi_defines.svh"
// Overview of operation
// - Wide variant drives a 32-bit data bus and up to 26 address bits.
// - Restricted variant uses only the 16-bit data bus for all transfers.
// - At least 20 address lines; wider variants extend to 24 or 26.
// - Address pin 31 carries the lowest-order address bit.
// - Data pin 31 is the LSB, pin 0 the MSB of the word.
// - Bus clock runs at half the system clock.
// - Strobe n qualifies data pins 8n to 8n+7.
// - Per chip select bit picks write enable or byte enable function.
// - Address pin 30 selects the 16-bit half in paired memories.
// - Word, half and byte accesses via per-lane strobes.
// - Configurable wait states per chip select, for pipelined memory.
// - A read stalls the core until the data returns.
module external_sram_bus #(
	parameter int ADDR_W   = `EBI_ADDR_W,
	parameter bit HALF_BUS = 1'b0,
	parameter int NUM_CS   = `EBI_NUM_CS
) (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    srst,
	// Core request
	input  wire logic                    req_valid,
	input  wire ebi_pkg::ebi_req_t       req,
	output logic                         req_ready,
	output logic                         core_stall,
	output logic [31:0]                  rdata,
	output logic                         rdata_valid,
	// Region configuration
	input  wire logic [NUM_CS-1:0][31:0] cs_base,
	input  wire logic [NUM_CS-1:0][31:0] cs_mask,
	input  wire logic [NUM_CS-1:0]       cs_enable,
	input  wire logic [NUM_CS-1:0]       cs_byte_en_mode,
	input  wire logic [NUM_CS-1:0][3:0]  cs_wait,
	// Memory pins
	output logic                         bus_clk,
	output logic [32-ADDR_W:31]          addr_pin,
	output logic [0:31]                  data_out,
	output logic                         data_oe_n,
	input  wire logic [0:31]             data_in,
	output logic [NUM_CS-1:0]            cs_n,
	output logic [0:3]                   byte_lane_strobe_n,
	output logic                         oe_n,
	output logic                         adv_n,
	output logic                         access_error
);
	// Burst of four beats
	localparam logic [1:0] LAST_BEAT = 2'h3;
	ebi_pkg::ebi_state_t state_q, state_d;
	logic                 div_q, div_d;
	logic [3:0]           ws_q, ws_d;
	logic [1:0]           beat_q, beat_d;
	logic [NUM_CS-1:0]    sel_q, sel_d, hit;
	ebi_pkg::ebi_req_t    cur_q, cur_d;
	logic [31:0]          rdata_d;
	logic                 rv_d, err_d;
	logic [3:0]           lanes;
	logic [31:0]          cur_addr;
	logic [31:0]          wsrc;
	logic                 one_hit;

	assign div_d = ~div_q;

	always_comb begin
		hit = '0;
		for (int i = 0; i < NUM_CS; i++) begin
			hit[i] = cs_enable[i] &
				((req.addr & cs_mask[i]) == (cs_base[i] & cs_mask[i]));
		end
	end
	assign one_hit = (hit != '0) && ((hit & (hit - 1'b1)) == '0);
	// Beat address from next values, so pins move with the beat
	assign cur_addr = {cur_d.addr[31:4], 2'(cur_d.addr[3:2] + beat_d),
		cur_d.addr[1:0]};

	// narrow bus: addressed half rides on pins 0-15
	// A word on the narrow bus moves its addressed half only
	always_comb begin
		wsrc = cur_d.wdata;
		if (HALF_BUS)
			wsrc = cur_d.addr[1] ? {cur_d.wdata[15:0], 16'h0000} :
				{cur_d.wdata[31:16], 16'h0000};
	end

	lane_strobe_gen #(
		.HALF_BUS (HALF_BUS)
	) u_lanes (
		.size    (cur_q.size),
		.addr_lo (cur_q.addr[1:0]),
		.lanes   (lanes)
	);

	// Sequencer; advances only on bus clock high phase, except done, which returns to idle on the next clock
	always_comb begin
		state_d = state_q;
		ws_d    = ws_q;
		beat_d  = beat_q;
		sel_d   = sel_q;
		cur_d   = cur_q;
		rdata_d = rdata;
		rv_d    = 1'b0;
		err_d   = 1'b0;
		case (state_q)
			ebi_pkg::st_idle: begin
				if (req_valid && div_q) begin
					if (one_hit) begin
						cur_d   = req;
						sel_d   = hit;
						beat_d  = 2'h0;
						state_d = ebi_pkg::st_addr;
					end else begin
						// Unmapped or overlapped: answer with error, no strobe
						err_d = 1'b1;
						rv_d  = ~req.write;
					end
				end
			end
			ebi_pkg::st_addr: begin
				if (div_q) begin
					ws_d = 4'h0;
					state_d = ebi_pkg::st_wait;
				end
			end
			ebi_pkg::st_wait: begin
				if (div_q) begin
					if (ws_q >= cs_wait[0]) begin
						state_d = ebi_pkg::st_data;
					end
					for (int i = 0; i < NUM_CS; i++) begin
						if (sel_q[i] && ws_q < cs_wait[i]) begin
							state_d = ebi_pkg::st_wait;
						end
						if (sel_q[i] && ws_q >= cs_wait[i]) begin
							state_d = ebi_pkg::st_data;
						end
					end
					ws_d = ws_q + 4'h1;
				end
			end
			ebi_pkg::st_data: begin
				if (div_q) begin
					if (!cur_q.write) begin
						rdata_d = data_in;
						// narrow bus returns the addressed half
						if (HALF_BUS)
							rdata_d = cur_q.addr[1] ?
								{16'h0000, data_in[0:15]} :
								{data_in[0:15], 16'h0000};
						rv_d    = 1'b1;
					end
					if (cur_q.burst && beat_q != LAST_BEAT) begin
						beat_d  = beat_q + 2'h1;
						state_d = ebi_pkg::st_wait;
						ws_d    = 4'h0;
					end else begin
						state_d = ebi_pkg::st_done;
					end
				end
			end
			ebi_pkg::st_done: begin
				sel_d   = '0;
				state_d = ebi_pkg::st_idle;
			end
			default: begin
				state_d = ebi_pkg::st_idle;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q  <= ebi_pkg::st_idle;
			div_q    <= 1'b0;
			ws_q     <= `EBI_WS_DEFAULT;
			beat_q   <= 2'h0;
			sel_q    <= '0;
			cur_q    <= '0;
			rdata    <= 32'h0000_0000;
			rdata_valid  <= 1'b0;
			access_error <= 1'b0;
		end else begin
			state_q  <= state_d;
			div_q    <= div_d;
			ws_q     <= ws_d;
			beat_q   <= beat_d;
			sel_q    <= sel_d;
			cur_q    <= cur_d;
			rdata    <= rdata_d;
			rdata_valid  <= rv_d;
			access_error <= err_d;
		end
	end

	// Pin registers, all outputs from flip-flops
	always_ff @(posedge clock) begin
		if (srst) begin
			bus_clk   <= 1'b0;
			addr_pin  <= '0;
			data_out  <= 32'h0000_0000;
			data_oe_n <= 1'b1;
			cs_n      <= '1;
			byte_lane_strobe_n <= 4'hf;
			oe_n      <= 1'b1;
			adv_n     <= 1'b1;
			req_ready <= 1'b0;
			core_stall <= 1'b0;
		end else begin
			// bus clock toggles every system clock
			bus_clk   <= div_d;
			// ADDR_W pins, 20 to 26 by variant
			// pin 31 gets address bit 0
			// pin 30 picks the 16-bit half
			for (int b = 32 - ADDR_W; b < 32; b++) begin
				addr_pin[b] <= cur_addr[31 - b];
			end
			// data pin 0 carries bit 31
			for (int b = 0; b < 32; b++) begin
				data_out[b] <= wsrc[31 - b];
			end
			// Data driven only while a write is in flight
			data_oe_n <= !(state_d != ebi_pkg::st_idle && cur_d.write);
			cs_n      <= ~sel_d;
			adv_n     <= !(state_d == ebi_pkg::st_addr);
			oe_n      <= !(state_d != ebi_pkg::st_idle &&
				state_d != ebi_pkg::st_done && !cur_d.write);
			for (int l = 0; l < 4; l++) begin
				byte_lane_strobe_n[l] <= !(lanes[l] &&
					(state_d == ebi_pkg::st_data) &&
					(cur_q.write || (|(sel_q & cs_byte_en_mode))));
			end
			req_ready  <= (state_d == ebi_pkg::st_idle) && div_d;
			core_stall <= (state_d != ebi_pkg::st_idle) && !cur_d.write;
		end
	end

	property p_one_cs;
		@(posedge clock) disable iff (srst)
		(state_q == ebi_pkg::st_data) |-> $onehot(~cs_n);
	endproperty
	a_one_cs: assert property (p_one_cs) else $error("cs not one-hot");
	property p_half;
		@(posedge clock) disable iff (srst)
		bus_clk |=> !bus_clk;
	endproperty
	a_half: assert property (p_half) else $error("bus clock rate");
	property p_stall;
		@(posedge clock) disable iff (srst)
		$rose(rdata_valid) && !access_error && state_q == ebi_pkg::st_done
			|-> $past(core_stall);
	endproperty
	a_stall: assert property (p_stall) else $error("read without stall");
	// select steady through waits and beats
	property p_cs_hold;
		@(posedge clock) disable iff (srst)
		(state_q == ebi_pkg::st_wait || state_q == ebi_pkg::st_data)
			|-> $stable(cs_n);
	endproperty
	a_cs_hold: assert property (p_cs_hold) else $error("cs moved");
	// write-enable region keeps strobes off on reads
	property p_we_read;
		@(posedge clock) disable iff (srst)
		(state_q == ebi_pkg::st_data && !cur_q.write &&
			(sel_q & cs_byte_en_mode) == '0) |-> (&byte_lane_strobe_n);
	endproperty
	a_we_read: assert property (p_we_read) else $error("read strobe");
	// low address bits on pins 30 and 31
	property p_addr_low;
		@(posedge clock) disable iff (srst)
		(state_q != ebi_pkg::st_idle) |->
			(addr_pin[30:31] == cur_q.addr[1:0]);
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("addr");
endmodule

/* sram_model.sv */
`timescale 1ns/1ps
// Flow-through memory behind the pins, word index from address bits 7:2
module sram_model (
	// Pins from the bus block
	input  wire logic        clock,
	input  wire logic [6:31] addr_pin,
	input  wire logic [0:31] data_out,
	input  wire logic        data_oe_n,
	input  wire logic [3:0]  cs_n,
	input  wire logic [0:3]  byte_lane_strobe_n,
	input  wire logic        oe_n,
	// Read data back to the block
	output logic      [0:31] data_in
);
	logic [31:0] mem [64];
	logic [31:0] last = 32'h0000_0000;
	logic [5:0]  idx;
	// pin 29 wired as word lsb
	assign idx = addr_pin[24:29];
	// Released bus shows the inverse, so a stale value never passes
	assign data_in = (!oe_n && !(&cs_n)) ? mem[idx] : ~last;
	// Byte lanes written under their own strobe
	always @(posedge clock) begin
		last <= data_in;
		if (!(&cs_n) && !data_oe_n)
			for (int l = 0; l < 4; l++)
				if (!byte_lane_strobe_n[l])
					mem[idx][31-8*l -: 8] <= data_out[8*l +: 8];
	end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
// Core requests in, pins watched, memory model behind
module testbench;
	// Core side
	logic              clock = 0, srst = 1, req_valid = 0;
	ebi_pkg::ebi_req_t req = '0;
	logic              req_ready, core_stall, rdata_valid, access_error;
	logic [31:0]       rdata;
	// Regions: select 0 write enables, select 1 byte enables, 2 waits
	logic [3:0][31:0]  cs_base = {64'h0, 32'h0001_0000, 32'h0000_0000};
	logic [3:0][31:0]  cs_mask = {4{32'hffff_0000}};
	logic [3:0]        cs_enable = 4'h3, cs_byte_en_mode = 4'h2;
	logic [3:0][3:0]   cs_wait = 16'h0020;
	// Pins and what the monitor saw
	logic              bus_clk, bus_q, rst_q, data_oe_n, oe_n, adv_n;
	logic              rd_strobe = 0;
	logic [6:31]       addr_pin, adr_q;
	logic [0:31]       data_out, data_in;
	logic [3:0]        cs_n, cs_q;
	logic [0:3]        byte_lane_strobe_n, wr_q;
	wire  [2:0]        ev = {access_error, rdata_valid, req_ready};
	int                n_errors = 0, checked = 0, cyc = 0, t0;

	external_sram_bus i_external_sram_bus (.clock, .srst, .req_valid,
		.req, .req_ready, .core_stall, .rdata, .rdata_valid, .cs_base,
		.cs_mask, .cs_enable, .cs_byte_en_mode, .cs_wait, .bus_clk,
		.addr_pin, .data_out, .data_oe_n,
		.data_in, .cs_n, .byte_lane_strobe_n, .oe_n, .adv_n,
		.access_error);
	sram_model i_sram_model (.clock, .addr_pin, .data_out, .data_oe_n,
		.cs_n, .byte_lane_strobe_n, .oe_n, .data_in);

	initial forever #12.5 clock = ~clock;

	// Compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Bounded wait: 0 ready, 1 read beat, 2 error pulse
	task automatic hit(input int s);
		int k = 0;
		do @(posedge clock);
		while (ev[s] !== 1'b1 && ++k < 99);
		// A wait that runs out is a mismatch
		if (ev[s] !== 1'b1) begin
			n_errors++;
			$display("ERROR %0t: no event %0d", $time, s);
		end
	endtask

	// One request, held until the edge that takes it
	task automatic go(input logic [31:0] a, input logic [31:0] d,
			input logic [1:0] sz, input logic w, input logic b);
		@(posedge clock);
		#1 req = '{a, d, sz, w, b};
		req_valid = 1;
		hit(0);
		t0 = cyc;
		#1 req_valid = 0;
	endtask

	// Pin monitor, also the hang limit
	always @(posedge clock) begin
		cyc <= cyc + 1;
		rst_q <= srst;
		bus_q <= bus_clk;
		if (cyc == 20000) begin
			n_errors++;
			end_sim;
		end
		if (!srst && !rst_q) begin
			chk(bus_clk, !bus_q);
			chk($countones(~cs_n) > 1, 0);
		end
		if (!adv_n) adr_q <= addr_pin;
		if (!adv_n) cs_q <= cs_n;
		if (!data_oe_n && byte_lane_strobe_n != 4'hf)
			wr_q <= byte_lane_strobe_n;
		// A taken request forgets read strobes seen before
		if (req_valid && req_ready)
			rd_strobe <= 0;
		else if (data_oe_n && byte_lane_strobe_n != 4'hf)
			rd_strobe <= 1;
	end

	// Word write, read back; core held while the read runs
	task automatic t_word;
		go(32'h0000_0044, 32'h1234_5678, 2'h2, 1, 0);
		go(32'h0000_0044, 32'h0000_0000, 2'h2, 0, 0);
		@(posedge clock);
		#1 chk(core_stall, 1);
		hit(1);
		chk(rdata, 32'h1234_5678);
		chk(adr_q, 32'h0000_0044);
		chk(wr_q, 4'h0);
	endtask

	// Each byte lane alone, then a half word, then read the word
	task automatic t_lanes;
		for (int a = 0; a < 4; a++) begin
			go(32'h80 + a, {4{8'(8'h11 * (a + 1))}}, 2'h0, 1, 0);
			hit(0);
			chk(wr_q, 4'hf ^ (4'h8 >> a));
		end
		go(32'h0000_0082, {2{16'ha5c3}}, 2'h1, 1, 0);
		hit(0);
		chk(wr_q, 4'hc);
		chk(adr_q[30], 1);
		go(32'h0000_0080, 32'h0000_0000, 2'h2, 0, 0);
		hit(1);
		chk(rdata, 32'h1122_a5c3);
	endtask

	// Strobe function and wait states differ per select
	task automatic t_modes;
		int l0;
		go(32'h0000_0044, 32'h0000_0000, 2'h2, 0, 0);
		hit(1);
		l0 = cyc - t0;
		chk(rd_strobe, 0);
		go(32'h0001_0044, 32'h0000_0000, 2'h2, 0, 0);
		hit(1);
		chk(rdata, 32'h1234_5678);
		chk(cyc - t0 - l0, 4);
		chk(rd_strobe, 1);
		chk(cs_q, 4'hd);
	endtask

	// Four beat burst, select held throughout
	task automatic t_burst;
		for (int i = 0; i < 4; i++)
			go(32'h40 + 4 * i, 32'ha0 + i, 2'h2, 1, 0);
		go(32'h0000_0040, 32'h0000_0000, 2'h2, 0, 1);
		for (int i = 0; i < 4; i++) begin
			hit(1);
			chk(rdata, 32'ha0 + i);
			chk(cs_n, 4'he);
		end
	endtask

	// Address outside every region
	task automatic t_err;
		go(32'h0100_0000, 32'h0000_0000, 2'h2, 0, 0);
		hit(2);
		chk(access_error, 1);
		chk(cs_n, 4'hf);
	endtask

	// Counts, verdict, stop
	task automatic end_sim;
		$display("Checks %0d, errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clock);
		#1 srst = 0;
		t_word;
		t_lanes;
		t_modes;
		t_burst;
		t_err;
		end_sim;
	end
endmodule
